// ==== nvm_pkg.sv ====
/*
 * Constants shared by the non-volatile memory controller register block
 * and its operation timer.
 * Assumes a 200 MHz system clock and a 12-bit byte offset inside the
 * controller's window.
 */
package nvm_pkg;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [11:0] OFS_IDLE = 12'h400;
  localparam logic [11:0] OFS_ACCEPT = 12'h408;
  localparam logic [11:0] OFS_MODE = 12'h504;
  localparam logic [11:0] OFS_ERASE_ALL = 12'h50c;
  localparam logic [11:0] OFS_DURATION = 12'h51c;
  localparam logic [11:0] OFS_ICACHE = 12'h540;
  localparam logic [11:0] OFS_HITS = 12'h548;
  localparam logic [11:0] OFS_MISS_COUNT_FIELD = 12'h54c;
  localparam logic [11:0] OFS_NS_MODE = 12'h584;
  localparam logic [11:0] OFS_NS_PROTECT = 12'h588;

  // ----------------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------------
  localparam int MODE_W = 3;
  localparam logic [2:0] MODE_READ = 3'h0;
  localparam logic [2:0] MODE_WRITE = 3'h1;
  localparam logic [2:0] MODE_ERASE = 3'h2;
  localparam logic [2:0] MODE_PARTIAL = 3'h4;
  localparam logic [2:0] MODE_RST = 3'h0;
  localparam logic [31:0] DURATION_RST = 32'h0000000a;
  localparam int CACHE_EN_BIT = 0;
  localparam int PROF_EN_BIT = 8;
  localparam logic [31:0] COUNT_RST = 32'h00000000;
  localparam int PROTECT_SET_BIT = 0;
  localparam int KEY_LSB = 4;
  localparam logic [27:0] PROTECT_KEY = 28'hafbe5a7;
  localparam logic [31:0] PAGE_ERASE_WORD = 32'hffffffff;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int T_WRITE_US = 43;
  localparam int T_ERASE_PAGE_MS = 87;
  localparam int T_ERASE_ALL_MS = 173;
  localparam int WRITE_CYCLES = T_WRITE_US * CLK_MHZ;
  localparam int MS_CYCLES = 1000 * CLK_MHZ;

endpackage : nvm_pkg

// ==== nvm_timer_if.sv ====
/*
 * Carrier between the register block and the operation timer.
 * Assumes both ends share one clock.
 */
`timescale 1ns/1ps
interface nvm_timer_if;
  logic start;
  logic [31:0] units;
  logic [31:0] unit_cycles;
  logic busy;
  logic done;

  modport ctrl (output start, output units, output unit_cycles,
                input busy, input done);
  modport timer (input start, input units, input unit_cycles,
                 output busy, output done);
endinterface : nvm_timer_if

// ==== nvm_op_timer.sv ====
/*
 * Times one write or erase operation as a number of units, each a number
 * of clock cycles.
 * Assumes start is a one-cycle pulse and never arrives while busy.
 */
`timescale 1ns/1ps
module nvm_op_timer (
  input wire logic clk,
  input wire logic rst_n,
  nvm_timer_if.timer tif
);

  typedef enum logic {IDLE, RUN} timer_state_t;

  timer_state_t state_reg, state_next;
  logic [31:0] cyc_reg, cyc_next;
  logic [31:0] left_reg, left_next;
  logic [31:0] span_reg, span_next;
  logic done_reg, done_next;

  always_comb begin
    state_next = state_reg;
    cyc_next = cyc_reg;
    left_next = left_reg;
    span_next = span_reg;
    done_next = 1'b0;
    unique case (state_reg)
      IDLE: begin
        if (tif.start) begin
          state_next = RUN;
          cyc_next = 32'h00000001;
          // A zero length still takes one unit
          left_next = (tif.units == 32'h0) ? 32'h1 : tif.units;
          span_next = tif.unit_cycles;
        end
      end
      RUN: begin
        if (cyc_reg >= span_reg) begin
          cyc_next = 32'h00000001;
          left_next = left_reg - 32'h1;
          if (left_reg == 32'h1) begin
            state_next = IDLE;
            done_next = 1'b1;
          end
        end else begin
          cyc_next = cyc_reg + 32'h1;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= IDLE;
      cyc_reg <= 32'h0;
      left_reg <= 32'h0;
      span_reg <= 32'h0;
      done_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cyc_reg <= cyc_next;
      left_reg <= left_next;
      span_reg <= span_next;
      done_reg <= done_next;
    end
  end

  assign tif.busy = (state_reg == RUN);
  assign tif.done = done_reg;

endmodule : nvm_op_timer

// ==== nvm_controller.sv ====
/*
 * Register block of the non-volatile memory controller: ready flags,
 * secure and non-secure access modes, chip erase, partial erase length,
 * instruction cache control and profiling counters.
 * Assumes a plain register port with read data one cycle after the read
 * strobe, and the flash array, cache and bus fabric outside.
 */
// Strobed register access was left to the implementer.
// Notes on behaviour
// - Idle flag reads 0 while busy, resets 1
// - Accept flag reads 1 when write possible
// - One-hot mode: 0 read, 1 write, 2/4 erase
// - Write (1) or erase (2) mode keeps cache invalidated; partial erase (4) does not
// - Writing 1 to trigger starts chip erase in erase mode (2) when idle
// - Partial erase length in ms, resets 0xa
// - Cache enable bit; clearing invalidates all entries
// - Hit counter, read-write, write zero clears
// - Miss counter, read-write, write zero clears
// - Non-secure view reaches only flags, ns registers
// - Counters advance per hit or miss
// - Non-secure mode register for non-secure writes
// - Fetches stall while write or erase runs
`timescale 1ns/1ps
module nvm_controller #(
  parameter int WRITE_CYCLES = nvm_pkg::WRITE_CYCLES,
  parameter int MS_CYCLES = nvm_pkg::MS_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic reg_nonsecure,
  output logic [31:0] reg_rdata,
  input wire logic nvm_wr_req,
  input wire logic nvm_wr_nonsecure,
  input wire logic nvm_wr_page_start,
  input wire logic [31:0] nvm_wr_data,
  input wire logic icache_hit,
  input wire logic icache_miss,
  output logic cache_enable,
  output logic cache_invalidate,
  output logic fetch_stall,
  output logic chip_erase_active,
  output logic protect_set_pulse
);

  nvm_timer_if tif ();

  nvm_op_timer u_timer (
    .clk(clk),
    .rst_n(rst_n),
    .tif(tif)
  );

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic legal_mode(input logic [31:0] v);
    return v[31:3] == 29'h0 && $onehot0(v[2:0]);
  endfunction : legal_mode

  function automatic logic ns_visible(input logic [11:0] a);
    return a == nvm_pkg::OFS_IDLE || a == nvm_pkg::OFS_ACCEPT ||
           a == nvm_pkg::OFS_NS_MODE || a == nvm_pkg::OFS_NS_PROTECT;
  endfunction : ns_visible

  logic [2:0] mode_reg, mode_next;
  logic [2:0] ns_mode_reg, ns_mode_next;
  logic [31:0] duration_reg, duration_next;
  logic cache_en_reg, cache_en_next;
  logic prof_en_reg, prof_en_next;
  logic [31:0] hits_reg, hits_next;
  logic [31:0] miss_count_field_reg, miss_count_field_next;
  logic [31:0] rdata_reg, rdata_next;
  logic inval_reg, inval_next;
  logic start_reg, start_next;
  logic [31:0] units_reg, units_next;
  logic [31:0] span_reg, span_next;
  logic erase_all_reg, erase_all_next;
  logic protect_reg, protect_next;

  logic wr_ok, rd_ok, pending, erase_all_go;
  logic [2:0] req_mode;
  logic is_page_erase;

  // A request is pending from the start pulse until the timer ends, so
  // a second request in the start cycle cannot slip in.
  assign pending = start_reg | tif.busy;
  assign wr_ok = reg_wr && (!reg_nonsecure || ns_visible(reg_addr));
  assign rd_ok = reg_rd && (!reg_nonsecure || ns_visible(reg_addr));
  assign req_mode = nvm_wr_nonsecure ? ns_mode_reg : mode_reg;
  assign is_page_erase = nvm_wr_page_start &&
                         nvm_wr_data == nvm_pkg::PAGE_ERASE_WORD;
  // Trigger write with erase mode starts chip erase
  // Any other mode leaves the trigger without effect
  assign erase_all_go = wr_ok && reg_addr == nvm_pkg::OFS_ERASE_ALL &&
                        reg_wdata[0] && mode_reg == nvm_pkg::MODE_ERASE &&
                        !pending;

  // ----------------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------------
  always_comb begin
    mode_next = mode_reg;
    ns_mode_next = ns_mode_reg;
    duration_next = duration_reg;
    cache_en_next = cache_en_reg;
    prof_en_next = prof_en_reg;
    protect_next = 1'b0;
    if (wr_ok) begin
      unique case (reg_addr)
        nvm_pkg::OFS_MODE: begin
          if (legal_mode(reg_wdata)) mode_next = reg_wdata[2:0];
        end
        nvm_pkg::OFS_NS_MODE: begin
          if (legal_mode(reg_wdata)) ns_mode_next = reg_wdata[2:0];
        end
        nvm_pkg::OFS_DURATION: duration_next = reg_wdata;
        nvm_pkg::OFS_ICACHE: begin
          cache_en_next = reg_wdata[nvm_pkg::CACHE_EN_BIT];
          prof_en_next = reg_wdata[nvm_pkg::PROF_EN_BIT];
        end
        nvm_pkg::OFS_NS_PROTECT: begin
          protect_next = reg_wdata[nvm_pkg::PROTECT_SET_BIT] &&
                         reg_wdata[31:nvm_pkg::KEY_LSB] ==
                         nvm_pkg::PROTECT_KEY;
        end
        default: ;
      endcase
    end
    // Held invalid in write/erase or with cache off
    inval_next = !cache_en_next ||
                 mode_next == nvm_pkg::MODE_WRITE ||
                 mode_next == nvm_pkg::MODE_ERASE ||
                 ns_mode_next == nvm_pkg::MODE_WRITE ||
                 ns_mode_next == nvm_pkg::MODE_ERASE;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mode_reg <= nvm_pkg::MODE_RST;
      ns_mode_reg <= nvm_pkg::MODE_RST;
      duration_reg <= nvm_pkg::DURATION_RST;
      cache_en_reg <= 1'b0;
      prof_en_reg <= 1'b0;
      protect_reg <= 1'b0;
      inval_reg <= 1'b1;
    end else begin
      mode_reg <= mode_next;
      ns_mode_reg <= ns_mode_next;
      duration_reg <= duration_next;
      cache_en_reg <= cache_en_next;
      prof_en_reg <= prof_en_next;
      protect_reg <= protect_next;
      inval_reg <= inval_next;
    end
  end

  // ----------------------------------------------------------------------
  // Operation launch
  // ----------------------------------------------------------------------
  always_comb begin
    start_next = 1'b0;
    units_next = units_reg;
    span_next = span_reg;
    erase_all_next = erase_all_reg;
    if (tif.done) erase_all_next = 1'b0;
    if (erase_all_go) begin
      start_next = 1'b1;
      units_next = 32'(nvm_pkg::T_ERASE_ALL_MS);
      span_next = 32'(MS_CYCLES);
      erase_all_next = 1'b1;
    end else if (nvm_wr_req && !pending) begin
      // Requests arriving while busy are dropped; software polls the
      // accept flag first.
      if (req_mode == nvm_pkg::MODE_WRITE) begin
        start_next = 1'b1;
        units_next = 32'h1;
        span_next = 32'(WRITE_CYCLES);
      end else if (req_mode == nvm_pkg::MODE_ERASE && is_page_erase) begin
        start_next = 1'b1;
        units_next = 32'(nvm_pkg::T_ERASE_PAGE_MS);
        span_next = 32'(MS_CYCLES);
      end else if (req_mode == nvm_pkg::MODE_PARTIAL && is_page_erase) begin
        start_next = 1'b1;
        units_next = duration_reg;
        span_next = 32'(MS_CYCLES);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      start_reg <= 1'b0;
      units_reg <= 32'h0;
      span_reg <= 32'h0;
      erase_all_reg <= 1'b0;
    end else begin
      start_reg <= start_next;
      units_reg <= units_next;
      span_reg <= span_next;
      erase_all_reg <= erase_all_next;
    end
  end

  assign tif.start = start_reg;
  assign tif.units = units_reg;
  assign tif.unit_cycles = span_reg;

  // ----------------------------------------------------------------------
  // Profiling counters and read port
  // ----------------------------------------------------------------------
  always_comb begin
    hits_next = hits_reg;
    miss_count_field_next = miss_count_field_reg;
    if (wr_ok && reg_addr == nvm_pkg::OFS_HITS) hits_next = reg_wdata;
    if (wr_ok && reg_addr == nvm_pkg::OFS_MISS_COUNT_FIELD) miss_count_field_next = reg_wdata;
    // A hit in the clearing cycle still counts
    if (prof_en_reg && icache_hit) hits_next = hits_next + 32'h1;
    if (prof_en_reg && icache_miss) miss_count_field_next = miss_count_field_next + 32'h1;
    rdata_next = 32'h0;
    if (rd_ok) begin
      unique case (reg_addr)
        nvm_pkg::OFS_IDLE: rdata_next = {31'h0, !pending};
        // Single operation, so accept tracks idle
        nvm_pkg::OFS_ACCEPT: rdata_next = {31'h0, !pending};
        nvm_pkg::OFS_MODE: rdata_next = {29'h0, mode_reg};
        nvm_pkg::OFS_NS_MODE: rdata_next = {29'h0, ns_mode_reg};
        nvm_pkg::OFS_DURATION: rdata_next = duration_reg;
        nvm_pkg::OFS_ICACHE: begin
          rdata_next[nvm_pkg::CACHE_EN_BIT] = cache_en_reg;
          rdata_next[nvm_pkg::PROF_EN_BIT] = prof_en_reg;
        end
        nvm_pkg::OFS_HITS: rdata_next = hits_reg;
        nvm_pkg::OFS_MISS_COUNT_FIELD: rdata_next = miss_count_field_reg;
        default: rdata_next = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hits_reg <= nvm_pkg::COUNT_RST;
      miss_count_field_reg <= nvm_pkg::COUNT_RST;
      rdata_reg <= 32'h0;
    end else begin
      hits_reg <= hits_next;
      miss_count_field_reg <= miss_count_field_next;
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign cache_enable = cache_en_reg;
  assign cache_invalidate = inval_reg;
  // Stall follows the timer's busy flop
  assign fetch_stall = tif.busy;
  assign chip_erase_active = erase_all_reg;
  assign protect_set_pulse = protect_reg;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence erase_all_req;
    wr_ok && reg_addr == nvm_pkg::OFS_ERASE_ALL && reg_wdata[0] &&
      mode_reg == nvm_pkg::MODE_ERASE && !pending;
  endsequence

  sequence launch_then_stall;
    start_reg && chip_erase_active ##1 fetch_stall;
  endsequence

  chk_idle_read: assert property (
    rd_ok && reg_addr == nvm_pkg::OFS_IDLE && pending |=> reg_rdata == 32'h0)
    else $error("idle flag read 1 while busy");
  chk_accept_read: assert property (
    rd_ok && reg_addr == nvm_pkg::OFS_ACCEPT && !pending
      |=> reg_rdata == 32'h1)
    else $error("accept flag read 0 while idle");
  chk_mode_onehot: assert property (
    $onehot0(mode_reg) && $onehot0(ns_mode_reg))
    else $error("access mode not one-hot");
  chk_cache_held: assert property (
    mode_reg == nvm_pkg::MODE_ERASE |-> cache_invalidate)
    else $error("cache valid in erase mode");
  chk_erase_launch: assert property (
    erase_all_req |=> launch_then_stall)
    else $error("chip erase did not start");
  chk_erase_ignored: assert property (
    wr_ok && reg_addr == nvm_pkg::OFS_ERASE_ALL &&
      mode_reg != nvm_pkg::MODE_ERASE && !nvm_wr_req |=> !start_reg)
    else $error("chip erase started outside erase mode");
  chk_duration_store: assert property (
    wr_ok && reg_addr == nvm_pkg::OFS_DURATION
      |=> duration_reg == $past(reg_wdata))
    else $error("partial erase length not stored");
  chk_cache_off: assert property (
    wr_ok && reg_addr == nvm_pkg::OFS_ICACHE && !reg_wdata[0]
      |=> !cache_enable && cache_invalidate)
    else $error("cache not disabled and invalidated");
  chk_hit_count: assert property (
    prof_en_reg && icache_hit && !(wr_ok && reg_addr == nvm_pkg::OFS_HITS)
      |=> hits_reg == $past(hits_reg) + 32'h1)
    else $error("hit counter did not advance");
  chk_miss_hold: assert property (
    !prof_en_reg && !(wr_ok && reg_addr == nvm_pkg::OFS_MISS_COUNT_FIELD)
      |=> $stable(miss_count_field_reg))
    else $error("miss counter moved without profiling");
  chk_ns_blocked: assert property (
    reg_wr && reg_nonsecure && reg_addr == nvm_pkg::OFS_MODE
      |=> $stable(mode_reg))
    else $error("non-secure write reached secure mode");
  chk_stall_ends: assert property (
    tif.done |-> !fetch_stall)
    else $error("stall held after operation end");

endmodule : nvm_controller

// ==== cpu_fetch_model.sv ====
/*
 * Processor and cache side model: emits instruction cache hit and miss
 * pulses and counts what it sent.
 * Assumes a random word from the bench each cycle and the design's
 * fetch stall output.
 */
`timescale 1ns/1ps
module cpu_fetch_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic [1:0] rnd,
  input wire logic fetch_stall,
  output logic icache_hit,
  output logic icache_miss,
  output logic [31:0] hits,
  output logic [31:0] miss_count_field
);
  // ----------------------------------------------------------------------
  // Fetch events
  // ----------------------------------------------------------------------
  // one event per fetch, none while stalled
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      icache_hit <= 1'b0;
      icache_miss <= 1'b0;
      hits <= 32'h0;
      miss_count_field <= 32'h0;
    end else begin
      icache_hit <= run && !fetch_stall && rnd[0] && rnd[1];
      icache_miss <= run && !fetch_stall && rnd[0] && !rnd[1];
      if (run && !fetch_stall && rnd[0]) begin
        if (rnd[1]) hits <= hits + 32'h1;
        else miss_count_field <= miss_count_field + 32'h1;
      end
    end
  end
endmodule : cpu_fetch_model

// ==== tb_top.sv ====
/*
 * Self-checking bench for the memory controller register block.
 * Assumes shortened timing parameters and a bench model kept in ints.
 */
`timescale 1ns/1ps
module tb_top;
  localparam int WC = 12;
  localparam int MC = 20;
  logic clk, rst_n, reg_wr, reg_rd, reg_nonsecure, run;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, nvm_wr_data, hits, miss_count_field, rdv;
  logic nvm_wr_req, nvm_wr_nonsecure, nvm_wr_page_start;
  logic icache_hit, icache_miss, cache_enable, cache_invalidate;
  logic fetch_stall, chip_erase_active, protect_set_pulse;
  logic [1:0] rnd;
  logic [31:0] run_len, last_len, seed;
  int err_count, samples_checked, prot_seen, ce_seen;
  int m_mode, m_dur, m_ic, base_h, base_m;

  nvm_controller #(.WRITE_CYCLES(WC), .MS_CYCLES(MC)) dut_u (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_nonsecure(reg_nonsecure),
    .reg_rdata(reg_rdata), .nvm_wr_req(nvm_wr_req),
    .nvm_wr_nonsecure(nvm_wr_nonsecure),
    .nvm_wr_page_start(nvm_wr_page_start), .nvm_wr_data(nvm_wr_data),
    .icache_hit(icache_hit), .icache_miss(icache_miss),
    .cache_enable(cache_enable), .cache_invalidate(cache_invalidate),
    .fetch_stall(fetch_stall), .chip_erase_active(chip_erase_active),
    .protect_set_pulse(protect_set_pulse));

  cpu_fetch_model cpu_u (.clk(clk), .rst_n(rst_n), .run(run), .rnd(rnd),
    .fetch_stall(fetch_stall), .icache_hit(icache_hit),
    .icache_miss(icache_miss), .hits(hits), .miss_count_field(miss_count_field));

  // ----------------------------------------------------------------------
  // Clock, random source, monitors
  // ----------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs

  always @(posedge clk) begin
    seed <= xs(seed);
    rnd <= seed[1:0];
    // Unknowns count as pulses so that they cannot hide a stray start
    if (protect_set_pulse !== 1'b0) prot_seen++;
    if (chip_erase_active !== 1'b0) ce_seen++;
    if (fetch_stall === 1'b1) run_len <= run_len + 32'h1;
    else if (run_len != 32'h0) begin
      last_len <= run_len;
      run_len <= 32'h0;
    end
  end

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input bit ns);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    reg_nonsecure <= ns;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a, input bit ns);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    reg_nonsecure <= ns;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rdv = reg_rdata;
  endtask : rd

  task automatic rchk(input logic [11:0] a, input bit ns, input int e);
    rd(a, ns);
    chk($sformatf("reg %h", a), rdv, e);
  endtask : rchk

  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask : settle

  task automatic flash_op(input logic [31:0] d, input bit pg, input int e);
    int i;
    @(posedge clk);
    nvm_wr_req <= 1'b1;
    nvm_wr_data <= d;
    nvm_wr_page_start <= pg;
    @(posedge clk);
    nvm_wr_req <= 1'b0;
    for (i = 0; i < 8 && fetch_stall !== 1'b1; i++) @(posedge clk);
    chk("stall rise", fetch_stall, 1'b1);
    rchk(nvm_pkg::OFS_IDLE, 1'b0, 0);
    rchk(nvm_pkg::OFS_ACCEPT, 1'b1, 0);
    for (i = 0; i < 4000 && fetch_stall !== 1'b0; i++) @(posedge clk);
    settle();
    chk("stall span", 32'(last_len >= e && last_len <= e + 2), 1);
    rchk(nvm_pkg::OFS_IDLE, 1'b1, 1);
  endtask : flash_op

  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : summarize

  initial begin
    repeat (30000) @(posedge clk);
    err_count++;
    summarize();
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    logic [11:0] ofs [9];
    int rst_v [9];
    int modes [4];
    int i;
    int pre;
    ofs = '{12'h400, 12'h408, 12'h504, 12'h51c, 12'h540, 12'h548, 12'h54c,
            12'h584, 12'h000};
    rst_v = '{1, 1, 0, 32'h0a, 0, 0, 0, 0, 0};
    modes = '{1, 2, 4, 0};
    {rst_n, reg_wr, reg_rd, reg_nonsecure, run} = 5'h0;
    {reg_addr, reg_wdata, nvm_wr_data} = 76'h0;
    {nvm_wr_req, nvm_wr_nonsecure, nvm_wr_page_start} = 3'h0;
    {err_count, samples_checked, prot_seen, ce_seen} = 128'h0;
    seed = 32'h60a9;
    rnd = 2'h0;
    run_len = 32'h0;
    last_len = 32'h0;
    m_mode = 0;
    m_dur = 32'h0a;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    // reset values and an unmapped hole
    for (i = 0; i < 9; i++) rchk(ofs[i], 1'b0, rst_v[i]);
    // every mode, cache held invalid for write and erase
    wr(nvm_pkg::OFS_ICACHE, 32'h1, 1'b0);
    for (i = 0; i < 4; i++) begin
      m_mode = modes[i];
      wr(nvm_pkg::OFS_MODE, m_mode, 1'b0);
      settle();
      chk("invalidate", cache_invalidate, m_mode == 1 || m_mode == 2);
      rchk(nvm_pkg::OFS_MODE, 1'b0, m_mode);
    end
    wr(nvm_pkg::OFS_MODE, 32'h3, 1'b0);
    rchk(nvm_pkg::OFS_MODE, 1'b0, m_mode);
    chk("cache on", cache_enable, 1'b1);
    wr(nvm_pkg::OFS_ICACHE, 32'h0, 1'b0);
    settle();
    chk("cache off", {cache_enable, cache_invalidate}, 2'b01);
    wr(nvm_pkg::OFS_MODE, 32'h1, 1'b1);
    rchk(nvm_pkg::OFS_MODE, 1'b0, m_mode);
    rchk(nvm_pkg::OFS_MODE, 1'b1, 0);
    wr(nvm_pkg::OFS_NS_MODE, 32'h1, 1'b1);
    rchk(nvm_pkg::OFS_NS_MODE, 1'b1, 1);
    pre = prot_seen;
    wr(nvm_pkg::OFS_NS_PROTECT, 32'hafbe5a71, 1'b1);
    wr(nvm_pkg::OFS_NS_PROTECT, 32'h12345671, 1'b1);
    settle();
    chk("protect", prot_seen - pre, 1);
    // non-secure word write times one unit
    nvm_wr_nonsecure <= 1'b1;
    flash_op(32'h0000a5a5, 1'b0, WC);
    nvm_wr_nonsecure <= 1'b0;
    wr(nvm_pkg::OFS_NS_MODE, 32'h0, 1'b1);
    m_dur = 1 + (seed & 32'h3);
    wr(nvm_pkg::OFS_DURATION, m_dur, 1'b0);
    rchk(nvm_pkg::OFS_DURATION, 1'b0, m_dur);
    wr(nvm_pkg::OFS_MODE, 32'h4, 1'b0);
    // enough partial steps to cover a full page erase
    for (i = 0; i * m_dur < nvm_pkg::T_ERASE_PAGE_MS; i++)
      flash_op(nvm_pkg::PAGE_ERASE_WORD, 1'b1, m_dur * MC);
    pre = ce_seen;
    wr(nvm_pkg::OFS_ERASE_ALL, 32'h1, 1'b0);
    // erase mode selected before the trigger
    wr(nvm_pkg::OFS_MODE, 32'h2, 1'b0);
    wr(nvm_pkg::OFS_ERASE_ALL, 32'h0, 1'b0);
    settle();
    chk("no erase", ce_seen - pre, 0);
    rchk(nvm_pkg::OFS_IDLE, 1'b0, 1);
    // chip erase runs its full time
    wr(nvm_pkg::OFS_ERASE_ALL, 32'h1, 1'b0);
    settle();
    chk("erase on", chip_erase_active, 1'b1);
    rchk(nvm_pkg::OFS_IDLE, 1'b0, 0);
    for (i = 0; i < 4000 && fetch_stall !== 1'b0; i++) @(posedge clk);
    settle();
    chk("erase span", 32'(last_len >= 173 * MC - 8), 1);
    chk("erase off", chip_erase_active, 1'b0);
    // Full page erase in erase mode, the longest single-step operation after chip erase
    flash_op(nvm_pkg::PAGE_ERASE_WORD, 1'b1, nvm_pkg::T_ERASE_PAGE_MS * MC);
    // back to read-only once erasing is done
    wr(nvm_pkg::OFS_MODE, 32'h0, 1'b0);
    // counters frozen while profiling is off
    wr(nvm_pkg::OFS_ICACHE, 32'h1, 1'b0);
    run <= 1'b1;
    repeat (30) @(posedge clk);
    run <= 1'b0;
    rchk(nvm_pkg::OFS_HITS, 1'b0, 0);
    rchk(nvm_pkg::OFS_MISS_COUNT_FIELD, 1'b0, 0);
    // counters follow the events while profiling
    base_h = hits;
    base_m = miss_count_field;
    m_ic = 32'h101;
    wr(nvm_pkg::OFS_ICACHE, m_ic, 1'b0);
    run <= 1'b1;
    repeat (60) @(posedge clk);
    run <= 1'b0;
    settle();
    rchk(nvm_pkg::OFS_ICACHE, 1'b0, m_ic);
    rchk(nvm_pkg::OFS_HITS, 1'b0, hits - base_h);
    rchk(nvm_pkg::OFS_MISS_COUNT_FIELD, 1'b0, miss_count_field - base_m);
    wr(nvm_pkg::OFS_HITS, 32'h5, 1'b0);
    rchk(nvm_pkg::OFS_HITS, 1'b0, 5);
    wr(nvm_pkg::OFS_HITS, 32'h0, 1'b0);
    wr(nvm_pkg::OFS_MISS_COUNT_FIELD, 32'h0, 1'b0);
    rchk(nvm_pkg::OFS_HITS, 1'b0, 0);
    rchk(nvm_pkg::OFS_MISS_COUNT_FIELD, 1'b0, 0);
    summarize();
  end
endmodule : tb_top
